// *** logic/frame_timing_defs.svh ***
// constants shared by the sensor timing end and the camera controller end
`ifndef FRAME_TIMING_DEFS_SVH
`define FRAME_TIMING_DEFS_SVH

// sequencer timing
`define CYC_PER_LINE      20'h00081
`define FOT_LANE_TERM     8'h20
`define EXP_START_DELAY   8'h85
`define MAX_OUT_CODE      3'h4
`define BITS_10_RATIO     4'hA
`define BITS_12_RATIO     4'hC

// configuration addresses
`define REG_LINES_LO      7'h01
`define REG_LINES_HI      7'h02
`define REG_EXP_0         7'h2A
`define REG_EXP_1         7'h2B
`define REG_EXP_2         7'h2C
`define REG_FRAMES_LO     7'h46
`define REG_FRAMES_HI     7'h47
`define REG_OUT_CODE      7'h48
`define REG_FOT_LEN       7'h49
`define REG_MODE          7'h4A

// configuration defaults
`define DEF_LINES_LO      8'h00
`define DEF_LINES_HI      8'h08
`define DEF_EXP_1         8'h04
`define DEF_FRAMES_LO     8'h01
`define DEF_OUT_CODE      8'h04
`define DEF_FOT_LEN       8'h14

// mode register bits
`define MODE_EXT          0
`define MODE_HDR          1
`define MODE_12B          2

// serial word layout
`define SPI_LAST_BIT      4'hF
`define SPI_ADDR_DONE     4'h7
`define SPI_HALF          3'h4
`define SPI_DATA_FIRST    5'h08
`define SPI_WORD_BITS     5'h10

// controller timing
`define CLK_PERIOD_NS     8
`define STARTUP_HOLD_NS   1000
`define STARTUP_HOLD_CYC  ((`STARTUP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_REQ_HOLD    2'h2

`endif

// *** logic/frame_timing_pkg.sv ***
// state types for the sensor timing end and the camera controller end
package frame_timing_pkg;

   typedef enum logic [2:0] {
      EXP_IDLE  = 3'b000,
      EXP_DELAY = 3'b001,
      EXP_WAIT  = 3'b010,
      EXP_RUN   = 3'b011,
      EXP_HOLD  = 3'b100
   } exp_state_t;

   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_FOT   = 2'b01,
      RD_LINES = 2'b10
   } rd_state_t;

   typedef enum logic [1:0] {
      SP_IDLE  = 2'b00,
      SP_LEAD  = 2'b01,
      SP_SHIFT = 2'b10,
      SP_TAIL  = 2'b11
   } spi_state_t;

endpackage

// *** logic/sensor_ctrl_if.sv ***
// control pins between camera controller and sensor timing end
`timescale 1ns/1ps
interface sensor_ctrl_if;
   logic system_reset_low;
   logic frame_req;
   logic spi_en;
   logic spi_clk;
   logic spi_in;
   logic spi_out;
   logic external_exposure_in;
   logic external_exposure_hdr_in;

   modport sensor (
      input  system_reset_low, frame_req, spi_en, spi_clk, spi_in,
      input  external_exposure_in, external_exposure_hdr_in,
      output spi_out
   );
   modport controller (
      output system_reset_low, frame_req, spi_en, spi_clk, spi_in,
      output external_exposure_in, external_exposure_hdr_in,
      input  spi_out
   );
endinterface

// *** logic/sensor_frame_timing.sv ***
// sensor end: input sampling, serial configuration and frame sequencer
`timescale 1ns/1ps
`include "frame_timing_defs.svh"

// Contract
// - sample every control input on clock rise
// - controller holds inputs at least one clock
// - reset low resets the sequencer
// - controller keeps reset low during start-up
// - frame request captures programmed frame count
// - serial transfers only while enable high
// - master clock is bit clock over 10/12
// - master clock at most 48/40 MHz; bench runs it at 125 MHz (8 ns)
// - master clock at least 5 MHz
// - overhead is (length + 32/outputs) times 129
// - overhead length resets to 20
// - read-out is 129/outputs cycles per line
// - overhead then image read-out
// - exposure runs parallel with read-out
// - one to sixteen outputs selectable
// - external exposure and HDR inputs
// - 16-bit word: control, 7 address, 8 data
// - reset returns registers to defaults
// - internal exposure starts 133 cycles after request
module sensor_frame_timing (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // pins from the controller
   sensor_ctrl_if.sensor         pins,
   // status
   output logic                  exposing_o,
   output logic                  fot_o,
   output logic                  reading_o,
   output logic                  frame_done_o,
   output logic                  busy_o,
   output logic [3:0]            bit_clk_ratio_o
);

   ////////////////////////////////////////////////////////////////////////////
   // input sampling

   logic        rst_q;
   logic        req_q;
   logic        req_prev;
   logic        en_q;
   logic        sclk_q;
   logic        sclk_prev;
   logic        sin_q;
   logic        te1_q;
   logic        te2_q;

   // every pin taken on the clock rise, levels held by the controller
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rst_q     <= 1'b1;
         req_q     <= 1'b0;
         req_prev  <= 1'b0;
         en_q      <= 1'b0;
         sclk_q    <= 1'b0;
         sclk_prev <= 1'b0;
         sin_q     <= 1'b0;
         te1_q     <= 1'b0;
         te2_q     <= 1'b0;
      end else begin
         rst_q     <= pins.system_reset_low;
         req_q     <= pins.frame_req;
         req_prev  <= req_q;
         en_q      <= pins.spi_en;
         sclk_q    <= pins.spi_clk;
         sclk_prev <= sclk_q;
         sin_q     <= pins.spi_in;
         te1_q     <= pins.external_exposure_in;
         te2_q     <= pins.external_exposure_hdr_in;
      end
   end

   // sequencer and registers drop together while the reset pin reads low
   wire seq_reset = !rstn_i || !rst_q;

   ////////////////////////////////////////////////////////////////////////////
   // serial configuration port

   logic [7:0]  cfg [0:127];
   logic [15:0] sh_in;
   logic [3:0]  bitcnt;
   logic [7:0]  sh_out;
   logic        rd_active;

   wire       sclk_rise = en_q && sclk_q && !sclk_prev;
   wire       sclk_fall = en_q && !sclk_q && sclk_prev;
   wire       wr_commit = sclk_rise && bitcnt == `SPI_LAST_BIT && sh_in[14];
   wire [6:0] wr_addr   = sh_in[13:7];
   wire [7:0] wr_data   = {sh_in[6:0], sin_q};
   wire       rd_load   = sclk_rise && bitcnt == `SPI_ADDR_DONE && !sh_in[6];
   wire [6:0] rd_addr   = {sh_in[5:0], sin_q};

   // shifter; the bit count wraps so bursts continue while enable stays high
   always_ff @(posedge clk_i) begin
      if (seq_reset || !en_q) begin
         sh_in     <= 16'h0000;
         bitcnt    <= 4'h0;
         rd_active <= 1'b0;
         sh_out    <= 8'h00;
         pins.spi_out <= 1'b0;
      end else begin
         if (sclk_rise) begin
            sh_in  <= {sh_in[14:0], sin_q};
            bitcnt <= bitcnt + 4'h1;
         end
         if (rd_load) begin
            sh_out    <= cfg[rd_addr];
            rd_active <= 1'b1;
         end else if (sclk_rise && bitcnt == `SPI_LAST_BIT) begin
            rd_active <= 1'b0;
         end else if (sclk_fall && rd_active) begin
            pins.spi_out <= sh_out[7];
            sh_out       <= {sh_out[6:0], 1'b0};
         end
      end
   end

   // register file; unlisted addresses default to zero
   always_ff @(posedge clk_i) begin
      if (seq_reset) begin
         for (int i = 0; i < 128; i++) begin
            cfg[i] <= 8'h00;
         end
         cfg[`REG_LINES_LO]  <= `DEF_LINES_LO;
         cfg[`REG_LINES_HI]  <= `DEF_LINES_HI;
         cfg[`REG_EXP_1]     <= `DEF_EXP_1;
         cfg[`REG_FRAMES_LO] <= `DEF_FRAMES_LO;
         cfg[`REG_OUT_CODE]  <= `DEF_OUT_CODE;
         cfg[`REG_FOT_LEN]   <= `DEF_FOT_LEN;
      end else if (wr_commit) begin
         cfg[wr_addr] <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer

   frame_timing_pkg::exp_state_t exp_st;
   frame_timing_pkg::rd_state_t  rd_st;
   logic [7:0]  dly_cnt;
   logic [23:0] exp_cnt;
   logic [19:0] rd_cnt;
   logic [15:0] frames_left;

   // lane count as a power of two: 1, 2, 4, 8 or 16 outputs
   wire [2:0]  out_code  = (cfg[`REG_OUT_CODE][2:0] > `MAX_OUT_CODE) ?
                           `MAX_OUT_CODE : cfg[`REG_OUT_CODE][2:0];
   wire [7:0]  lane_term = `FOT_LANE_TERM >> out_code;
   wire [19:0] fot_cyc   = 20'(({12'h000, cfg[`REG_FOT_LEN]} + {12'h000, lane_term})
                           * `CYC_PER_LINE);
   wire [11:0] nr_lines  = {cfg[`REG_LINES_HI][3:0], cfg[`REG_LINES_LO]};
   wire [19:0] img_cyc   = 20'((`CYC_PER_LINE * {8'h00, nr_lines}) >> out_code);
   wire [23:0] exp_len   = {cfg[`REG_EXP_2], cfg[`REG_EXP_1], cfg[`REG_EXP_0]};
   wire [15:0] frame_cnt = {cfg[`REG_FRAMES_HI], cfg[`REG_FRAMES_LO]};
   wire        ext_mode  = cfg[`REG_MODE][`MODE_EXT];
   wire        hdr_mode  = cfg[`REG_MODE][`MODE_HDR];
   // a new request counts only on its rising level and while idle
   wire        req_start = req_q && !req_prev && exp_st == frame_timing_pkg::EXP_IDLE
                           && rd_st == frame_timing_pkg::RD_IDLE;
   wire        ext_open  = te1_q || (hdr_mode && te2_q);
   wire        kick_fot  = exp_st == frame_timing_pkg::EXP_HOLD
                           && rd_st == frame_timing_pkg::RD_IDLE;

   // exposure engine; a finished exposure waits for the read-out to free up
   always_ff @(posedge clk_i) begin
      if (seq_reset) begin
         exp_st      <= frame_timing_pkg::EXP_IDLE;
         dly_cnt     <= 8'h00;
         exp_cnt     <= 24'h000000;
         frames_left <= 16'h0000;
      end else begin
         case (exp_st)
            frame_timing_pkg::EXP_IDLE: begin
               if (req_start && frame_cnt != 16'h0000) begin
                  frames_left <= frame_cnt;
                  dly_cnt     <= 8'h01;
                  exp_st      <= ext_mode ? frame_timing_pkg::EXP_WAIT
                                          : frame_timing_pkg::EXP_DELAY;
               end
            end
            frame_timing_pkg::EXP_DELAY: begin
               dly_cnt <= dly_cnt + 8'h01;
               if (dly_cnt == `EXP_START_DELAY) begin
                  exp_cnt <= exp_len;
                  exp_st  <= frame_timing_pkg::EXP_RUN;
               end
            end
            frame_timing_pkg::EXP_WAIT: begin
               if (te1_q) begin
                  exp_st <= frame_timing_pkg::EXP_RUN;
               end
            end
            frame_timing_pkg::EXP_RUN: begin
               exp_cnt <= exp_cnt - 24'h000001;
               if (ext_mode ? !ext_open : exp_cnt <= 24'h000001) begin
                  exp_st <= frame_timing_pkg::EXP_HOLD;
               end
            end
            frame_timing_pkg::EXP_HOLD: begin
               if (kick_fot) begin
                  frames_left <= frames_left - 16'h0001;
                  exp_cnt     <= exp_len;
                  // next exposure overlaps this frame's read-out
                  if (frames_left == 16'h0001) begin
                     exp_st <= frame_timing_pkg::EXP_IDLE;
                  end else if (ext_mode) begin
                     exp_st <= frame_timing_pkg::EXP_WAIT;
                  end else begin
                     exp_st <= frame_timing_pkg::EXP_RUN;
                  end
               end
            end
            default: exp_st <= frame_timing_pkg::EXP_IDLE;
         endcase
      end
   end

   // read-out engine: overhead then line read-out
   always_ff @(posedge clk_i) begin
      if (seq_reset) begin
         rd_st  <= frame_timing_pkg::RD_IDLE;
         rd_cnt <= 20'h00000;
      end else begin
         case (rd_st)
            frame_timing_pkg::RD_IDLE: begin
               if (kick_fot) begin
                  rd_cnt <= fot_cyc;
                  rd_st  <= frame_timing_pkg::RD_FOT;
               end
            end
            frame_timing_pkg::RD_FOT: begin
               rd_cnt <= rd_cnt - 20'h00001;
               if (rd_cnt <= 20'h00001) begin
                  rd_cnt <= img_cyc;
                  rd_st  <= frame_timing_pkg::RD_LINES;
               end
            end
            frame_timing_pkg::RD_LINES: begin
               rd_cnt <= rd_cnt - 20'h00001;
               if (rd_cnt <= 20'h00001) begin
                  rd_st <= frame_timing_pkg::RD_IDLE;
               end
            end
            default: rd_st <= frame_timing_pkg::RD_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status outputs, one cycle behind the engines

   always_ff @(posedge clk_i) begin
      if (seq_reset) begin
         exposing_o      <= 1'b0;
         fot_o           <= 1'b0;
         reading_o       <= 1'b0;
         frame_done_o    <= 1'b0;
         busy_o          <= 1'b0;
         bit_clk_ratio_o <= `BITS_10_RATIO;
      end else begin
         exposing_o   <= exp_st == frame_timing_pkg::EXP_RUN;
         fot_o        <= rd_st == frame_timing_pkg::RD_FOT;
         reading_o    <= rd_st == frame_timing_pkg::RD_LINES;
         frame_done_o <= rd_st == frame_timing_pkg::RD_LINES && rd_cnt <= 20'h00001;
         busy_o       <= exp_st != frame_timing_pkg::EXP_IDLE
                         || rd_st != frame_timing_pkg::RD_IDLE;
         // bit clock must run this many times the master clock
         bit_clk_ratio_o <= cfg[`REG_MODE][`MODE_12B] ? `BITS_12_RATIO
                                                      : `BITS_10_RATIO;
      end
   end

endmodule

// *** logic/camera_controller.sv ***
// controller end: reset, frame request, serial programming and exposure pins
`timescale 1ns/1ps
`include "frame_timing_defs.svh"

module camera_controller (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   // user requests
   input  wire logic             reset_req_i,
   input  wire logic             frame_start_i,
   input  wire logic             spi_go_i,
   input  wire logic             spi_write_i,
   input  wire logic [6:0]       spi_addr_i,
   input  wire logic [7:0]       spi_wdata_i,
   input  wire logic             ext_exp_i,
   input  wire logic             ext_hdr_i,
   // user status
   output logic                  ready_o,
   output logic                  spi_busy_o,
   output logic                  spi_done_o,
   output logic [7:0]            spi_rdata_o,
   // pins to the sensor
   sensor_ctrl_if.controller     pins
);

   ////////////////////////////////////////////////////////////////////////////
   // reset and frame request pins

   logic [7:0] hold_cnt;
   logic [1:0] req_cnt;

   // sensor reset held low for the start-up time after any reset
   always_ff @(posedge clk_i) begin
      if (!rstn_i || reset_req_i) begin
         hold_cnt              <= 8'(`STARTUP_HOLD_CYC);
         pins.system_reset_low <= 1'b0;
         ready_o               <= 1'b0;
      end else if (hold_cnt != 8'h00) begin
         hold_cnt <= hold_cnt - 8'h01;
      end else begin
         pins.system_reset_low <= 1'b1;
         ready_o               <= 1'b1;
      end
   end

   // request held two clocks so one sampling edge always sees it
   always_ff @(posedge clk_i) begin
      if (!rstn_i || !ready_o) begin
         req_cnt        <= 2'h0;
         pins.frame_req <= 1'b0;
      end else if (frame_start_i && req_cnt == 2'h0) begin
         req_cnt        <= `FRAME_REQ_HOLD;
         pins.frame_req <= 1'b1;
      end else if (req_cnt != 2'h0) begin
         req_cnt        <= req_cnt - 2'h1;
         pins.frame_req <= req_cnt != 2'h1;
      end
   end

   // exposure pins are registered levels
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pins.external_exposure_in     <= 1'b0;
         pins.external_exposure_hdr_in <= 1'b0;
      end else begin
         pins.external_exposure_in     <= ext_exp_i;
         pins.external_exposure_hdr_in <= ext_hdr_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial programming, clock is the master clock over twice SPI_HALF

   frame_timing_pkg::spi_state_t sp_st;
   logic [2:0]  ph_cnt;
   logic [4:0]  bit_idx;
   logic [15:0] sh;
   logic        is_read;

   wire ph_end = ph_cnt == `SPI_HALF - 3'h1;

   always_ff @(posedge clk_i) begin
      if (!rstn_i || !ready_o) begin
         sp_st        <= frame_timing_pkg::SP_IDLE;
         ph_cnt       <= 3'h0;
         bit_idx      <= 5'h00;
         sh           <= 16'h0000;
         is_read      <= 1'b0;
         spi_busy_o   <= 1'b0;
         spi_done_o   <= 1'b0;
         spi_rdata_o  <= 8'h00;
         pins.spi_en  <= 1'b0;
         pins.spi_clk <= 1'b0;
         pins.spi_in  <= 1'b0;
      end else begin
         spi_done_o <= 1'b0;
         ph_cnt     <= ph_end ? 3'h0 : ph_cnt + 3'h1;
         case (sp_st)
            frame_timing_pkg::SP_IDLE: begin
               ph_cnt <= 3'h0;
               if (spi_go_i) begin
                  // control bit first, then address and data, msb first
                  sh          <= {spi_write_i, spi_addr_i, spi_wdata_i};
                  is_read     <= !spi_write_i;
                  pins.spi_in <= spi_write_i;
                  pins.spi_en <= 1'b1;
                  spi_busy_o  <= 1'b1;
                  bit_idx     <= 5'h00;
                  sp_st       <= frame_timing_pkg::SP_LEAD;
               end
            end
            frame_timing_pkg::SP_LEAD: begin
               if (ph_end) begin
                  sp_st <= frame_timing_pkg::SP_SHIFT;
               end
            end
            frame_timing_pkg::SP_SHIFT: begin
               if (ph_end) begin
                  pins.spi_clk <= !pins.spi_clk;
                  if (!pins.spi_clk) begin
                     // read data sampled on rise, sensor launched it on fall
                     if (is_read && bit_idx >= `SPI_DATA_FIRST) begin
                        spi_rdata_o <= {spi_rdata_o[6:0], pins.spi_out};
                     end
                  end else if (bit_idx == `SPI_WORD_BITS - 5'h01) begin
                     sp_st <= frame_timing_pkg::SP_TAIL;
                  end else begin
                     bit_idx     <= bit_idx + 5'h01;
                     pins.spi_in <= sh[14];
                     sh          <= {sh[14:0], 1'b0};
                  end
               end
            end
            frame_timing_pkg::SP_TAIL: begin
               // enable stays high one more serial clock period
               if (ph_end) begin
                  pins.spi_clk <= !pins.spi_clk;
                  if (pins.spi_clk) begin
                     pins.spi_en <= 1'b0;
                     spi_busy_o  <= 1'b0;
                     spi_done_o  <= 1'b1;
                     sp_st       <= frame_timing_pkg::SP_IDLE;
                  end
               end
            end
            default: sp_st <= frame_timing_pkg::SP_IDLE;
         endcase
      end
   end

endmodule

// *** verif/image_sensor_frame_timing_control_checker.sv ***
// assertions on the sensor control pins and the sensor status outputs
`timescale 1ns/1ps
module image_sensor_frame_timing_control_checker (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // control pins
   input  wire logic       system_reset_low,
   input  wire logic       frame_req,
   input  wire logic       spi_en,
   input  wire logic       spi_clk,
   input  wire logic       spi_out,
   // sensor status
   input  wire logic       ext_mode,
   input  wire logic       exposing_o,
   input  wire logic       fot_o,
   input  wire logic       reading_o,
   input  wire logic       frame_done_o,
   input  wire logic       busy_o,
   input  wire logic [3:0] bit_clk_ratio_o
);
   logic [7:0] rel_cnt;
   logic [4:0] rise_cnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////
   // cycles the sensor reset has stayed low, saturating
   always_ff @(posedge clk_i) begin
      if (!rstn_i || system_reset_low) rel_cnt <= 8'h00;
      else if (rel_cnt != 8'hFF) rel_cnt <= rel_cnt + 8'h01;
   end
   // serial clock rises inside one enable frame
   always_ff @(posedge clk_i) begin
      if (!rstn_i || !spi_en) rise_cnt <= 5'h00;
      else if ($rose(spi_clk)) rise_cnt <= rise_cnt + 5'h01;
   end
   ////////////////////////////////////////////////////////////
   AST_RESET_HOLD: assert property ($rose(system_reset_low) |-> rel_cnt >= 8'h7C)
      else $error("sensor reset released too early");
   AST_REQ_HOLD: assert property ($rose(frame_req) |=> frame_req)
      else $error("frame request shorter than two cycles");
   AST_CLK_IN_FRAME: assert property ($rose(spi_clk) |-> spi_en)
      else $error("serial clock edge outside enable");
   AST_EN_LEAD: assert property ($rose(spi_en) |-> !spi_clk)
      else $error("serial clock high at enable rise");
   AST_BIT_COUNT: assert property ($fell(spi_en) |-> rise_cnt == 5'h11)
      else $error("wrong number of serial clock rises");
   AST_OUT_IN_LOW: assert property ($changed(spi_out) |-> !spi_clk)
      else $error("serial output changed while clock high");
   AST_EXP_DELAY: assert property ($rose(frame_req) && !busy_o && !ext_mode |->
      ##[134:137] $rose(exposing_o))
      else $error("exposure start delay wrong");
   AST_SEQ_RESET: assert property (!system_reset_low [*3] |=>
      !busy_o && !fot_o && !reading_o && !exposing_o)
      else $error("sequencer not reset");
   AST_FOT_TO_READ: assert property ($fell(fot_o) && system_reset_low |-> reading_o)
      else $error("read-out does not follow overhead");
   AST_DONE_AFTER_READ: assert property ($fell(reading_o) && system_reset_low |->
      $past(frame_done_o))
      else $error("no frame done after read-out");
   AST_RATIO: assert property (bit_clk_ratio_o == 4'hA || bit_clk_ratio_o == 4'hC)
      else $error("bit clock ratio illegal");
endmodule

// *** verif/image_sensor_frame_timing_control_tb_top.sv ***
// self-checking bench joining the camera controller end to the sensor timing end
`timescale 1ns/1ps
`include "frame_timing_defs.svh"
module image_sensor_frame_timing_control_tb_top;
   logic       clk_i, rstn_i, reset_req_i, frame_start_i, spi_go_i, spi_write_i;
   logic       ext_exp_i, ext_hdr_i, ready_o, spi_busy_o, spi_done_o;
   logic       exposing_o, fot_o, reading_o, frame_done_o, busy_o;
   logic [6:0] spi_addr_i;
   logic [7:0] spi_wdata_i, spi_rdata_o, d;
   logic [3:0] bit_clk_ratio_o;
   int         failures, check_count, cyc, fl, nl, c;
   integer     seed;
   logic [6:0] def_addr [5] = '{`REG_FOT_LEN, `REG_OUT_CODE, `REG_LINES_HI, `REG_FRAMES_LO, 7'h10};
   logic [7:0] def_val [5] = '{`DEF_FOT_LEN, `DEF_OUT_CODE, `DEF_LINES_HI, `DEF_FRAMES_LO, 8'h00};
   ////////////////////////////////////////////////////////////
   sensor_ctrl_if ctrl_if ();
   sensor_frame_timing u_sensor_frame_timing (.clk_i(clk_i), .rstn_i(rstn_i),
      .pins(ctrl_if.sensor), .exposing_o(exposing_o), .fot_o(fot_o), .reading_o(reading_o),
      .frame_done_o(frame_done_o), .busy_o(busy_o), .bit_clk_ratio_o(bit_clk_ratio_o));
   camera_controller u_camera_controller (.clk_i(clk_i), .rstn_i(rstn_i),
      .reset_req_i(reset_req_i), .frame_start_i(frame_start_i), .spi_go_i(spi_go_i),
      .spi_write_i(spi_write_i), .spi_addr_i(spi_addr_i), .spi_wdata_i(spi_wdata_i),
      .ext_exp_i(ext_exp_i), .ext_hdr_i(ext_hdr_i), .ready_o(ready_o),
      .spi_busy_o(spi_busy_o), .spi_done_o(spi_done_o), .spi_rdata_o(spi_rdata_o),
      .pins(ctrl_if.controller));
   image_sensor_frame_timing_control_checker u_checker (.clk_i(clk_i), .rstn_i(rstn_i),
      .system_reset_low(ctrl_if.system_reset_low), .frame_req(ctrl_if.frame_req),
      .spi_en(ctrl_if.spi_en), .spi_clk(ctrl_if.spi_clk), .spi_out(ctrl_if.spi_out),
      .exposing_o(exposing_o), .fot_o(fot_o), .reading_o(reading_o),
      .frame_done_o(frame_done_o), .busy_o(busy_o), .bit_clk_ratio_o(bit_clk_ratio_o),
      .ext_mode(u_sensor_frame_timing.ext_mode));
   ////////////////////////////////////////////////////////////
   // expected counts, worked out apart from the design
   function automatic int fot_cyc(input int f, input int code);
      return (f + (32 >> code)) * 129;
   endfunction
   function automatic int img_cyc(input int lines, input int code);
      return (129 * lines) >> code;
   endfunction
   // one comparison, x never matches
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one serial word; go is a one-cycle pulse, then wait for done
   task automatic spi(input logic wr, input logic [6:0] a, input logic [7:0] v);
      int n;
      spi_go_i <= 1'b1;
      spi_write_i <= wr;
      spi_addr_i <= a;
      spi_wdata_i <= v;
      @(posedge clk_i);
      spi_go_i <= 1'b0;
      n = 0;
      while (spi_done_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      check(n < 400, 1);
      @(posedge clk_i);
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      while (ready_o !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check(ready_o, 1);
   endtask
   // request frames, count overhead, read-out and done cycles until idle
   task automatic run_frames(input int nf, input int f, input int code, input int lines);
      int fc, rc, dc, ov, n, idle;
      fc = 0;
      rc = 0;
      dc = 0;
      ov = 0;
      n = 0;
      idle = 0;
      frame_start_i <= 1'b1;
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      while ((busy_o === 1'b1 || idle < 4) && n < 60000) begin
         @(posedge clk_i);
         ext_exp_i <= 1'($random(seed));
         ext_hdr_i <= 1'($random(seed));
         fc += int'(fot_o === 1'b1);
         rc += int'(reading_o === 1'b1);
         dc += int'(frame_done_o === 1'b1);
         ov |= int'(exposing_o === 1'b1 && fot_o === 1'b1);
         idle = (busy_o === 1'b1) ? 0 : idle + 1;
         n++;
      end
      check(fc, nf * fot_cyc(f, code));
      check(rc, nf * img_cyc(lines, code));
      check(dc, nf);
      if (nf > 1) check(ov, 1);
   endtask
   ////////////////////////////////////////////////////////////
   always #4 clk_i = ~clk_i;
   // hang guard, far above the expected run length
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      seed = 32'heae31368;
      clk_i = 1'b0;
      rstn_i = 1'b0;
      reset_req_i = 1'b0;
      frame_start_i = 1'b0;
      spi_go_i = 1'b0;
      spi_write_i = 1'b0;
      spi_addr_i = 7'h00;
      spi_wdata_i = 8'h00;
      ext_exp_i = 1'b0;
      ext_hdr_i = 1'b0;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      wait_ready();
      // start-up values, an unmapped address among them
      for (int i = 0; i < 5; i++) begin
         spi(1'b0, def_addr[i], 8'h00);
         check(spi_rdata_o, def_val[i]);
      end
      check(bit_clk_ratio_o, 4'hA);
      repeat (3) begin
         d = 8'($random(seed));
         spi(1'b1, `REG_EXP_0, d);
         spi(1'b0, `REG_EXP_0, 8'h00);
         check(spi_rdata_o, d);
      end
      spi(1'b1, `REG_MODE, 8'h04);
      check(bit_clk_ratio_o, 4'hC);
      spi(1'b1, `REG_MODE, 8'h00);
      check(bit_clk_ratio_o, 4'hA);
      spi(1'b1, `REG_EXP_1, 8'h00);
      spi(1'b1, `REG_EXP_0, 8'h40);
      // every output count, random overhead length and line count
      for (c = 0; c <= 4; c++) begin
         fl = {$random(seed)} % 16;
         nl = {$random(seed)} % 12 + 4;
         spi(1'b1, `REG_FOT_LEN, 8'(fl));
         spi(1'b1, `REG_OUT_CODE, 8'(c));
         spi(1'b1, `REG_LINES_LO, 8'(nl));
         spi(1'b1, `REG_LINES_HI, 8'h00);
         run_frames(1, fl, c, nl);
      end
      spi(1'b1, `REG_FRAMES_LO, 8'h02);
      run_frames(2, fl, 4, nl);
      spi(1'b1, `REG_MODE, 8'h03);
      run_frames(2, fl, 4, nl);
      spi(1'b1, `REG_MODE, 8'h00);
      // sensor reset in mid-frame must clear the sequencer and return registers to defaults
      frame_start_i <= 1'b1;
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      repeat (300) @(posedge clk_i);
      reset_req_i <= 1'b1;
      @(posedge clk_i);
      reset_req_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wait_ready();
      check(busy_o, 0);
      spi(1'b0, `REG_FRAMES_LO, 8'h00);
      check(spi_rdata_o, `DEF_FRAMES_LO);
      spi(1'b0, `REG_FOT_LEN, 8'h00);
      check(spi_rdata_o, `DEF_FOT_LEN);
      close_out();
   end
endmodule
